// ===== rtl/vic_pkg.sv
/*
  Shared constants and types of the vectored interrupt controller:
  register offsets, mode field layout, reset values and the bus carrier.
  Assumes a byte-addressed register port with 32-bit aligned words.
*/
package vic_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_SOURCES = 32;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int SRC_W       = 5;
  localparam int LEVEL_W     = 3;
  localparam int FAST_SRC    = 0;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_MODE_BASE    = 12'h000;
  localparam logic [11:0] OFS_HANDLER_BASE = 12'h080;
  localparam logic [11:0] OFS_NORMAL_VEC   = 12'h100;
  localparam logic [11:0] OFS_FAST_VEC     = 12'h104;
  localparam logic [11:0] OFS_CUR_SRC      = 12'h108;
  localparam logic [11:0] OFS_PENDING      = 12'h10c;
  localparam logic [11:0] OFS_ENABLE       = 12'h110;
  localparam logic [11:0] OFS_EN_CMD       = 12'h120;
  localparam logic [11:0] OFS_DIS_CMD      = 12'h124;
  localparam logic [11:0] OFS_DONE_CMD     = 12'h130;
  localparam logic [11:0] OFS_FALLBACK     = 12'h134;
  localparam logic [11:0] OFS_EVT_STATUS   = 12'h140;
  localparam logic [11:0] OFS_EVT_CLEAR    = 12'h144;
  localparam logic [11:0] OFS_EVT_ENABLE   = 12'h148;

  // Mode and handler tables each span 32 words: upper address bits select the table
  localparam logic [4:0]  TABLE_MODE       = 5'h00;
  localparam logic [4:0]  TABLE_HANDLER    = 5'h01;

  // ==========================================================
  // Mode register field positions
  localparam int URG_LSB  = 0;
  localparam int TRIG_LSB = 5;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
  localparam logic [31:0] HANDLER_RESET  = 32'h0000_0000;
  localparam logic [31:0] FALLBACK_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET   = 32'h0000_0000;

  // ==========================================================
  // Event status bits
  localparam int EVT_W          = 3;
  localparam int EVT_SPUR_NORM  = 0;
  localparam int EVT_SPUR_FAST  = 1;
  localparam int EVT_STACK_OVF  = 2;

  // ==========================================================
  // Types
  typedef logic [LEVEL_W-1:0] vic_level_t;

  typedef struct packed {
    logic [1:0] trigger_kind;
    vic_level_t urgency_level;
  } vic_mode_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } vic_bus_req_t;

  typedef struct packed {
    logic             busy;
    vic_level_t       level;
    logic [SRC_W-1:0] source;
  } vic_ctx_t;

  localparam vic_ctx_t CTX_IDLE = '{busy: 1'b0, level: 3'h0, source: 5'h00};

endpackage

// ===== rtl/vic_trigger.sv
/*
  One interrupt source: pin synchroniser, polarity and level/edge
  detection, and the pending flag.
  Assumes the raw source is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module vic_trigger #(
  parameter bit EXTERNAL = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       src_raw,
  input  wire logic [1:0] trigger_kind,
  input  wire logic       ack,
  output logic            pending
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic pend_ff;
  logic high_pol;
  logic active;
  logic edge_mode;

  // Internal sources cannot be inverted: polarity bit only counts outside
  assign high_pol  = EXTERNAL ? trigger_kind[1] : 1'b1;          // [RULE_03] [RULE_04]
  assign active    = high_pol ? sync_ff : ~sync_ff;              // [RULE_03]
  assign edge_mode = trigger_kind[0];                            // [RULE_03] [RULE_04]
  assign pending   = pend_ff;

  // Synchroniser keeps sampling through reset, so the pin level is settled
  // when reset lifts and an idle-high low-level pin shows no false pending
  always_ff @(posedge clk) begin
    meta_ff <= src_raw;
    sync_ff <= meta_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= active;
    end
  end

  // A new edge in the acknowledge cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_ff <= 1'b0;
    end else if (edge_mode) begin
      if (active && !prev_ff) begin
        pend_ff <= 1'b1;
      end else if (ack) begin
        pend_ff <= 1'b0;
      end
    end else begin
      pend_ff <= active;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/vic_arbiter.sv
/*
  Combinational priority pick among the normal sources.
  Assumes pending, enable and levels are registered by the caller.
*/
`timescale 1ns/10ps
`default_nettype none

module vic_arbiter
  import vic_pkg::*;
(
  input  wire logic [vic_pkg::NUM_SOURCES-1:0] pending,
  input  wire logic [vic_pkg::NUM_SOURCES-1:0] enabled,
  input  wire vic_pkg::vic_level_t [vic_pkg::NUM_SOURCES-1:0] levels,
  input  wire logic                            busy,
  input  wire vic_pkg::vic_level_t             cur_level,
  output logic                                 found,
  output logic [vic_pkg::SRC_W-1:0]            src
);
  vic_level_t best;

  // Ties go to the lowest source number; source 0 never competes here
  always_comb begin
    found = 1'b0;
    src   = 5'h00;
    best  = 3'h0;
    for (int i = 1; i < NUM_SOURCES; i++) begin                  // [RULE_02]
      if (pending[i] && enabled[i] && (!busy || levels[i] > cur_level) &&
          (!found || levels[i] > best)) begin                    // [RULE_17]
        found = 1'b1;
        src   = SRC_W'(i);
        best  = levels[i];
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/vic_top.sv
/*
  Vectored interrupt controller, register view: 32 sources, source 0 fast,
  per-source mode and handler tables, vector reads with a priority stack.
  Assumes a one-cycle register port with read data in the next cycle, and
  that software issues the service-done command after each vector read.
*/
// Our own choices: strobed register access and the address map.
// How it works
// (RULE_01) Each normal source mode holds a 3-bit urgency, 0 lowest, 7 highest.
// (RULE_02) Fast source 0 urgency is ignored when arbitrating.
// (RULE_03) Two-bit trigger kind: low level, falling, high level, rising for external.
// (RULE_04) Internal sources use only level or edge, always high or rising.
// (RULE_05) Each of 32 sources has a 32-bit read/write handler address.
// (RULE_06) Normal vector read returns handler of the source now serviced.
// (RULE_07) Handler chosen by the current interrupt found at the read.
// (RULE_08) No current interrupt: normal vector read returns the fallback vector.
// (RULE_09) Fast vector read returns handler address 0.
// (RULE_10) No fast interrupt: fast vector read returns the fallback vector.
// (RULE_11) Current source register returns the serviced source number.
// (RULE_12) Pending register bit reads 1 while its source is pending.
// (RULE_13) Bit 0 fast, bit 1 platform controller, bits 2 to 31 peripherals.
// (RULE_14) Enable state bit reads 1 when enabled, 0 when disabled.
// (RULE_15) Normal vector read records, stacks current level and acknowledges. With the stack full the code acknowledges but neither records nor stacks.
// (RULE_16) Software issues service-done after servicing; controller pops the stack.
// (RULE_17) Winner is enabled, pending, non-fast, highest and above the serviced level.
`timescale 1ns/10ps
`default_nettype none

module vic_top #(
  parameter logic [31:0] EXTERNAL_SOURCES = 32'h0000_0000,
  parameter int          STACK_DEPTH      = 8
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic [vic_pkg::NUM_SOURCES-1:0] src_in,
  input  wire vic_pkg::vic_bus_req_t           bus_req,
  output logic [vic_pkg::DATA_W-1:0]           rd_data,
  output logic                                 normal_req,
  output logic                                 fast_req,
  output logic                                 event_irq
);
  import vic_pkg::*;

  localparam int          DEPTH_W    = $clog2(STACK_DEPTH + 1);
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = DEPTH_W'(STACK_DEPTH);
  localparam logic [DEPTH_W-1:0] DEPTH_ONE  = DEPTH_W'(1);

  // ==========================================================
  // State
  vic_mode_t                mode_ff     [NUM_SOURCES];
  logic [DATA_W-1:0]        handler_ff  [NUM_SOURCES];
  logic [DATA_W-1:0]        fallback_ff;
  logic [NUM_SOURCES-1:0]   enable_ff;
  logic [EVT_W-1:0]         evt_status_ff;
  logic [EVT_W-1:0]         evt_enable_ff;
  vic_ctx_t                 stack_ff    [STACK_DEPTH];
  logic [DEPTH_W-1:0]       depth_ff;
  vic_ctx_t                 cur_ff;
  logic [DATA_W-1:0]        rd_data_ff;
  logic                     normal_req_ff;
  logic                     fast_req_ff;
  logic                     event_irq_ff;

  // ==========================================================
  // Decode
  logic                     wr;
  logic                     rd;
  logic [4:0]               table_sel;
  logic [SRC_W-1:0]         slot;
  logic                     hit_mode;
  logic                     hit_handler;
  logic                     read_normal;
  logic                     read_fast;
  logic                     write_done;

  assign wr          = bus_req.wr;
  assign rd          = bus_req.rd;
  assign table_sel   = bus_req.addr[11:7];
  assign slot        = bus_req.addr[6:2];
  assign hit_mode    = (table_sel == TABLE_MODE);
  assign hit_handler = (table_sel == TABLE_HANDLER);
  assign read_normal = rd && (bus_req.addr == OFS_NORMAL_VEC);
  assign read_fast   = rd && (bus_req.addr == OFS_FAST_VEC);
  assign write_done  = wr && (bus_req.addr == OFS_DONE_CMD);

  // ==========================================================
  // Sources and arbitration
  logic [NUM_SOURCES-1:0]   pending;
  logic [NUM_SOURCES-1:0]   ack_vec;
  vic_level_t [NUM_SOURCES-1:0] levels;
  logic                     arb_found;
  logic [SRC_W-1:0]         arb_src;
  logic                     fast_live;

  assign fast_live = pending[FAST_SRC] && enable_ff[FAST_SRC];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_src
      // Reading a vector acknowledges the source it hands out
      assign ack_vec[gi] = (gi == FAST_SRC) ? (read_fast && fast_live) :
                           (read_normal && arb_found &&
                            (arb_src == SRC_W'(gi)));            // [RULE_15]
      assign levels[gi]  = mode_ff[gi].urgency_level;

      vic_trigger #(
        .EXTERNAL (EXTERNAL_SOURCES[gi])
      ) u_trig (
        .clk          (clk),
        .reset        (reset),
        .src_raw      (src_in[gi]),
        .trigger_kind (mode_ff[gi].trigger_kind),
        .ack          (ack_vec[gi]),
        .pending      (pending[gi])
      );
    end
  endgenerate

  vic_arbiter u_arb (
    .pending   (pending),
    .enabled   (enable_ff),
    .levels    (levels),
    .busy      (cur_ff.busy),
    .cur_level (cur_ff.level),
    .found     (arb_found),
    .src       (arb_src)
  );

  // ==========================================================
  // Mode and handler tables
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_SOURCES; i++) begin
        mode_ff[i] <= vic_mode_t'(MODE_RESET[4:0]);
      end
    end else if (wr && hit_mode) begin
      mode_ff[slot].urgency_level <= bus_req.wdata[URG_LSB +: LEVEL_W];  // [RULE_01]
      mode_ff[slot].trigger_kind  <= bus_req.wdata[TRIG_LSB +: 2];       // [RULE_03]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_SOURCES; i++) begin
        handler_ff[i] <= HANDLER_RESET;
      end
    end else if (wr && hit_handler) begin
      handler_ff[slot] <= bus_req.wdata;                         // [RULE_05]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fallback_ff <= FALLBACK_RESET;
    end else if (wr && bus_req.addr == OFS_FALLBACK) begin
      fallback_ff <= bus_req.wdata;
    end
  end

  // Enable and disable commands; both in one word cannot happen on this port
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_ff <= ENABLE_RESET;
    end else if (wr && bus_req.addr == OFS_EN_CMD) begin
      enable_ff <= enable_ff | bus_req.wdata;
    end else if (wr && bus_req.addr == OFS_DIS_CMD) begin
      enable_ff <= enable_ff & ~bus_req.wdata;
    end
  end

  // ==========================================================
  // Service context and priority stack
  logic stack_full;
  assign stack_full = (depth_ff == DEPTH_FULL);

  // A spurious read still stacks the context while the stack is not full, so one service-done balances it
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff   <= CTX_IDLE;
      depth_ff <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_ff[i] <= CTX_IDLE;
      end
    end else if (read_normal && !stack_full) begin
      stack_ff[depth_ff[DEPTH_W-2:0]] <= cur_ff;                 // [RULE_15]
      depth_ff <= depth_ff + DEPTH_ONE;
      if (arb_found) begin
        cur_ff <= '{busy: 1'b1, level: levels[arb_src], source: arb_src};  // [RULE_11]
      end
    end else if (write_done) begin
      if (depth_ff != '0) begin
        cur_ff   <= stack_ff[depth_ff[DEPTH_W-2:0] - 1'b1];      // [RULE_16]
        depth_ff <= depth_ff - DEPTH_ONE;
      end else begin
        cur_ff <= CTX_IDLE;
      end
    end
  end

  // ==========================================================
  // Events and interrupt output
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  assign evt_set[EVT_SPUR_NORM] = read_normal && !arb_found;
  assign evt_set[EVT_SPUR_FAST] = read_fast && !fast_live;
  assign evt_set[EVT_STACK_OVF] = read_normal && stack_full;
  assign evt_clr = (wr && bus_req.addr == OFS_EVT_CLEAR) ? bus_req.wdata[EVT_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      evt_status_ff <= '0;
    end else begin
      evt_status_ff <= (evt_status_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evt_enable_ff <= '0;
    end else if (wr && bus_req.addr == OFS_EVT_ENABLE) begin
      evt_enable_ff <= bus_req.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      event_irq_ff  <= 1'b0;
      normal_req_ff <= 1'b0;
      fast_req_ff   <= 1'b0;
    end else begin
      event_irq_ff  <= |(evt_status_ff & evt_enable_ff);
      normal_req_ff <= arb_found;                                // [RULE_17]
      fast_req_ff   <= fast_live;
    end
  end

  // ==========================================================
  // Read path
  logic [DATA_W-1:0] rd_value;

  always_comb begin
    rd_value = '0;
    if (hit_mode) begin
      rd_value[URG_LSB +: LEVEL_W] = mode_ff[slot].urgency_level;  // [RULE_01]
      rd_value[TRIG_LSB +: 2]      = mode_ff[slot].trigger_kind;
    end else if (hit_handler) begin
      rd_value = handler_ff[slot];                               // [RULE_05]
    end else begin
      case (bus_req.addr)
        OFS_NORMAL_VEC: rd_value = arb_found ? handler_ff[arb_src] : fallback_ff;  // [RULE_06] [RULE_07] [RULE_08]
        OFS_FAST_VEC:   rd_value = fast_live ? handler_ff[FAST_SRC] : fallback_ff; // [RULE_09] [RULE_10]
        OFS_CUR_SRC:    rd_value[SRC_W-1:0] = cur_ff.source;     // [RULE_11]
        OFS_PENDING:    rd_value = pending;                      // [RULE_12] [RULE_13]
        OFS_ENABLE:     rd_value = enable_ff;                    // [RULE_14] [RULE_13]
        OFS_FALLBACK:   rd_value = fallback_ff;
        OFS_EVT_STATUS: rd_value[EVT_W-1:0] = evt_status_ff;
        OFS_EVT_ENABLE: rd_value[EVT_W-1:0] = evt_enable_ff;
        default:        rd_value = '0;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_ff <= '0;
    end else if (rd) begin
      rd_data_ff <= rd_value;
    end else begin
      rd_data_ff <= '0;
    end
  end

  assign rd_data    = rd_data_ff;
  assign normal_req = normal_req_ff;
  assign fast_req   = fast_req_ff;
  assign event_irq  = event_irq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  mode_field_a: assert property (rd && hit_mode |=> rd_data_ff[31:8] == 24'h0 && // [RULE_01]
      rd_data_ff[2:0] == $past(levels[slot]))
    else $error("mode read wrong");

  fast_ignored_a: assert property (arb_found |-> arb_src != 5'h00) // [RULE_02]
    else $error("fast source won normal arbitration");

  vector_read_a: assert property (read_normal && arb_found |=> // [RULE_06]
      rd_data_ff == handler_ff[$past(arb_src)])
    else $error("normal vector not handler of winner");

  spurious_read_a: assert property (read_normal && !arb_found |=> // [RULE_08]
      rd_data_ff == $past(fallback_ff) && evt_status_ff[EVT_SPUR_NORM])
    else $error("spurious read not fallback");

  fast_vector_a: assert property (read_fast |=> // [RULE_09]
      rd_data_ff == ($past(fast_live) ? handler_ff[0] : $past(fallback_ff)))
    else $error("fast vector read wrong");

  current_source_a: assert property (read_normal && arb_found && !stack_full |=> // [RULE_11]
      cur_ff.busy && cur_ff.source == $past(arb_src))
    else $error("current source not recorded");

  pending_view_a: assert property (rd && bus_req.addr == OFS_PENDING |=> // [RULE_12]
      rd_data_ff == $past(pending))
    else $error("pending view wrong");

  enable_view_a: assert property (rd && bus_req.addr == OFS_ENABLE |=> // [RULE_14]
      rd_data_ff == $past(enable_ff))
    else $error("enable view wrong");

  stack_push_a: assert property (read_normal && !stack_full |=> // [RULE_15]
      depth_ff == $past(depth_ff) + DEPTH_ONE)
    else $error("vector read did not stack");

  above_level_a: assert property (arb_found && cur_ff.busy |-> // [RULE_17]
      levels[arb_src] > cur_ff.level ##1 normal_req_ff)
    else $error("winner not above serviced level");

  fast_fallback_a: assert property (read_fast && !fast_live |=> // [RULE_10]
      rd_data_ff == $past(fallback_ff) && evt_status_ff[EVT_SPUR_FAST])
    else $error("spurious fast read not fallback");

  source_view_a: assert property (rd && bus_req.addr == OFS_CUR_SRC |=> // [RULE_11]
      rd_data_ff == {27'h0, $past(cur_ff.source)})
    else $error("current source view wrong");

  handler_store_a: assert property (wr && hit_handler |=> // [RULE_05]
      handler_ff[$past(slot)] == $past(bus_req.wdata))
    else $error("handler write lost");

  enable_cmd_a: assert property (wr && bus_req.addr == OFS_EN_CMD |=> // [RULE_14]
      enable_ff == ($past(enable_ff) | $past(bus_req.wdata)))
    else $error("enable command not applied");

  stack_pop_a: assert property (write_done && depth_ff != '0 |=> // [RULE_16]
      depth_ff == $past(depth_ff) - DEPTH_ONE)
    else $error("service done did not pop");

endmodule

`default_nettype wire

// ===== tb/vic_core_model.sv
/*
  Behavioural model of the processor core that receives the normal and
  fast interrupt requests; one instance per request line.
  Assumes the request is an active-high level, registered on clk.
*/
`timescale 1ns/10ps
`default_nettype none

module vic_core_model #(
  parameter int DELAY = 1
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic req,
  output logic      taken
);
  int cnt_ff;

  // ==========================================================
  // Request acceptance
  // A request must stand DELAY cycles before the core takes it, so a
  // short glitch is missed just as a core busy mid-instruction would.
  always_ff @(posedge clk) begin
    if (reset || !req) begin
      cnt_ff <= 0;
    end else if (cnt_ff < DELAY) begin
      cnt_ff <= cnt_ff + 1;
    end
  end

  assign taken = req && (cnt_ff == DELAY);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench of the interrupt controller register view.
  Assumes the one-cycle register port of vic_top and the core model.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import vic_pkg::*;

  localparam logic [31:0] FALLBACK = 32'h5a5a_0f0f;

  logic                   clk;
  logic                   reset;
  logic [NUM_SOURCES-1:0] src_in;
  vic_bus_req_t           bus_req;
  logic [DATA_W-1:0]      rd_data;
  logic                   normal_req;
  logic                   fast_req;
  logic                   event_irq;
  logic                   normal_taken;
  logic                   fast_taken;
  int                     err_total;
  int                     checked;

  // Source 2 is the one external source, so its polarity can be reached
  vic_top #(.EXTERNAL_SOURCES(32'h0000_0004), .STACK_DEPTH(8)) i_dut (
    .clk(clk), .reset(reset), .src_in(src_in), .bus_req(bus_req),
    .rd_data(rd_data), .normal_req(normal_req), .fast_req(fast_req),
    .event_irq(event_irq));
  vic_core_model #(.DELAY(1)) i_core_normal (
    .clk(clk), .reset(reset), .req(normal_req), .taken(normal_taken));
  vic_core_model #(.DELAY(4)) i_core_fast (
    .clk(clk), .reset(reset), .req(fast_req), .taken(fast_taken));

  // ==========================================================
  // Access tasks
  function automatic logic [31:0] hv(input int n);
    hv = {16'h4e00, 11'h000, n[4:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk(rd_data, exp, $sformatf("read %h", a));
  endtask

  task automatic setsrc(input logic [31:0] v);
    @(posedge clk);
    src_in <= v;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, reset and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ==========================================================
  // Tests
  initial begin
    err_total = 0;
    checked   = 0;
    reset     = 1'b1;
    src_in    = 32'h0000_0004;
    bus_req   = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;

    rd(OFS_PENDING, 32'h0);
    rd(OFS_ENABLE, 32'h0);
    rd(OFS_CUR_SRC, 32'h0);
    rd(OFS_HANDLER_BASE + 12'h07c, 32'h0);
    rd(12'h200, 32'h0);
    $display("end of test reset");

    for (int n = 0; n < NUM_SOURCES; n++) wr(OFS_HANDLER_BASE + 12'(4 * n), hv(n));
    wr(OFS_FALLBACK, FALLBACK);
    wr(12'h200, 32'hffff_ffff);
    for (int n = 0; n < NUM_SOURCES; n++) rd(OFS_HANDLER_BASE + 12'(4 * n), hv(n));
    wr(OFS_MODE_BASE + 12'h014, 32'hffff_ffff);
    rd(OFS_MODE_BASE + 12'h014, 32'h0000_0067);
    rd(12'h200, 32'h0);
    $display("end of test tables");

    // Source 3 internal high level, source 4 internal rising edge
    wr(OFS_MODE_BASE + 12'h010, 32'h0000_0020);
    setsrc(32'h0000_0018);
    idle(5);
    rd(OFS_PENDING, 32'h0000_001c);
    setsrc(32'h0000_0004);
    idle(5);
    rd(OFS_PENDING, 32'h0000_0010);
    // Source 2 external falling edge: the pin drops from its idle high
    wr(OFS_MODE_BASE + 12'h008, 32'h0000_0020);
    setsrc(32'h0000_0000);
    idle(5);
    rd(OFS_PENDING, 32'h0000_0014);
    $display("end of test triggers");

    wr(OFS_EN_CMD, 32'h0000_0017);
    wr(OFS_DIS_CMD, 32'h0000_0010);
    rd(OFS_ENABLE, 32'h0000_0007);
    $display("end of test enable");

    // Fast source urgency 7 must not beat source 2 in the normal pick
    wr(OFS_MODE_BASE, 32'h0000_0007);
    wr(OFS_MODE_BASE + 12'h004, 32'h0000_0002);
    wr(OFS_MODE_BASE + 12'h008, 32'h0000_0045);
    setsrc(32'h0000_0007);
    idle(10);
    chk({31'h0, normal_req}, 32'h1, "normal request");
    chk({31'h0, fast_req}, 32'h1, "fast request");
    chk({30'h0, normal_taken, fast_taken}, 32'h3, "core took requests");
    rd(OFS_NORMAL_VEC, hv(2));
    rd(OFS_CUR_SRC, 32'h2);
    idle(2);
    chk({31'h0, normal_req}, 32'h0, "request under level");
    rd(OFS_NORMAL_VEC, FALLBACK);
    wr(OFS_DONE_CMD, 32'h0);
    wr(OFS_DONE_CMD, 32'h0);
    setsrc(32'h0000_0003);
    idle(5);
    rd(OFS_NORMAL_VEC, hv(1));
    rd(OFS_CUR_SRC, 32'h1);
    wr(OFS_DONE_CMD, 32'h0);
    rd(OFS_FAST_VEC, hv(0));
    setsrc(32'h0000_0002);
    idle(5);
    rd(OFS_FAST_VEC, FALLBACK);
    chk({31'h0, fast_req}, 32'h0, "fast request idle");
    $display("end of test vectors");

    rd(OFS_EVT_STATUS, 32'h3);
    chk({31'h0, event_irq}, 32'h0, "event masked");
    wr(OFS_EVT_ENABLE, 32'h1);
    idle(2);
    chk({31'h0, event_irq}, 32'h1, "event raised");
    rd(OFS_EVT_ENABLE, 32'h1);
    wr(OFS_EVT_CLEAR, 32'h1);
    idle(2);
    chk({31'h0, event_irq}, 32'h0, "event cleared");
    rd(OFS_EVT_STATUS, 32'h2);
    $display("end of test events");

    report_and_stop();
  end
endmodule
`default_nettype wire
